// ===== arnv_ctrl.sv
// Purpose: add-on reset control and external nv memory byte access register
// Assumes: add-on bus writes and reads are single-cycle strobes on i_ref_clk
// Notes:   nv memory pin timing lives outside; this block drives a request/ack port
`timescale 1ns/1ps
module arnv_ctrl
  import arnv_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_sel,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  output logic      [31:0]            o_rdata,
  output logic                        o_mbox_flags_clr,
  output logic                        o_ptrd_fifo_rst,
  output arnv_nv_req_t                o_nv_req,
  input  wire logic                   i_nv_ack,
  input  wire logic [ARNV_DATA_W-1:0] i_nv_rdata
);
  typedef enum logic {ARNV_IDLE, ARNV_BUSY} arnv_state_t;

  arnv_state_t            state;
  arnv_op_t               op;
  logic [ARNV_DATA_W-1:0] data;
  logic                   reg_wr;
  logic                   start;
  arnv_op_t               wr_op;

  assign reg_wr = i_sel && i_wr && (i_addr == ARNV_REG_OFFSET);
  assign wr_op  = arnv_op_t'(i_wdata[ARNV_OP_HI_BIT:ARNV_OP_LO_BIT]);
  // accesses start only from idle with the enable bit written as one
  assign start  = reg_wr && (state == ARNV_IDLE) && i_wdata[ARNV_EN_BIT];

  // software reset pulses
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mbox_flags_clr <= 1'b0;
      o_ptrd_fifo_rst  <= 1'b0;
    end else begin
      o_mbox_flags_clr <= reg_wr && i_wdata[ARNV_MBOX_CLR_BIT];
      o_ptrd_fifo_rst  <= reg_wr && i_wdata[ARNV_FIFO_RST_BIT];
    end
  end

  a_mbox_clr_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && i_wdata[ARNV_MBOX_CLR_BIT]
    |=> o_mbox_flags_clr
        ##1 (!o_mbox_flags_clr || $past(reg_wr && i_wdata[ARNV_MBOX_CLR_BIT])))
    else $error("mailbox flag clear pulse missing");

  a_mbox_clr_source: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_mbox_flags_clr
    |-> $past(reg_wr && i_wdata[ARNV_MBOX_CLR_BIT]))
    else $error("mailbox flag clear without request");

  a_fifo_rst_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_ptrd_fifo_rst |-> $past(reg_wr && i_wdata[ARNV_FIFO_RST_BIT]))
    else $error("fifo reset pulse without request");

  a_fifo_rst_req: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && i_wdata[ARNV_FIFO_RST_BIT]
    |=> o_ptrd_fifo_rst)
    else $error("fifo reset pulse missing");

  a_fifo_rst_end: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_ptrd_fifo_rst && !(reg_wr && i_wdata[ARNV_FIFO_RST_BIT])
    |=> !o_ptrd_fifo_rst)
    else $error("fifo reset pulse too long");

  // access state: address loads finish at once, write and read wait for ack
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ARNV_IDLE;
      op    <= ARNV_OP_ADDR_LO;
    end else begin
      unique case (state)
        ARNV_IDLE: begin
          if (reg_wr) begin
            op <= wr_op;
          end
          if (start && (wr_op == ARNV_OP_WRITE || wr_op == ARNV_OP_READ)) begin
            state <= ARNV_BUSY;
          end
        end
        ARNV_BUSY: begin
          if (i_nv_ack) begin
            state <= ARNV_IDLE;
          end
        end
      endcase
    end
  end

  a_op_latch: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && state == ARNV_IDLE
    |=> op == $past(wr_op))
    else $error("operation code not latched");

  a_busy_refuse: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && state == ARNV_BUSY && !i_nv_ack
    |=> state == ARNV_BUSY && $stable(op) && $stable(data) && $stable(o_nv_req))
    else $error("write taken while busy");

  a_busy_holds: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == ARNV_BUSY && !i_nv_ack
    |=> state == ARNV_BUSY && (o_nv_req.wr || o_nv_req.rd))
    else $error("ready reported before ack");

  a_ack_ready: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == ARNV_BUSY && i_nv_ack
    |=> state == ARNV_IDLE && !o_nv_req.wr && !o_nv_req.rd)
    else $error("ready not reported after ack");

  a_addr_no_busy: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    start && (wr_op == ARNV_OP_ADDR_LO || wr_op == ARNV_OP_ADDR_HI)
    |=> state == ARNV_IDLE && !o_nv_req.wr && !o_nv_req.rd)
    else $error("address load started a memory access");

  a_disabled_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && state == ARNV_IDLE && !i_wdata[ARNV_EN_BIT]
    |=> state == ARNV_IDLE && !o_nv_req.wr && !o_nv_req.rd)
    else $error("access started with enable low");

  // data byte, address bytes and memory request
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data     <= '0;
      o_nv_req <= '0;
    end else begin
      if (reg_wr && state == ARNV_IDLE) begin
        data <= i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W];
      end
      if (start) begin
        unique case (wr_op)
          ARNV_OP_ADDR_LO: o_nv_req.addr[7:0]  <= i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W];
          ARNV_OP_ADDR_HI: o_nv_req.addr[15:8] <= i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W];
          ARNV_OP_WRITE: begin
            o_nv_req.wdata <= i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W];
            o_nv_req.wr    <= 1'b1;
          end
          ARNV_OP_READ:    o_nv_req.rd <= 1'b1;
        endcase
      end
      if (state == ARNV_BUSY && i_nv_ack) begin
        o_nv_req.wr <= 1'b0;
        o_nv_req.rd <= 1'b0;
        if (o_nv_req.rd) begin
          data <= i_nv_rdata;
        end
      end
    end
  end

  a_addr_lo_load: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    start && wr_op == ARNV_OP_ADDR_LO
    |=> o_nv_req.addr[7:0] == $past(i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W])
        && state == ARNV_IDLE)
    else $error("low address byte not loaded");

  a_addr_hi_load: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    start && wr_op == ARNV_OP_ADDR_HI
    |=> o_nv_req.addr[15:8] == $past(i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W]))
    else $error("high address byte not loaded");

  a_write_start: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    start && wr_op == ARNV_OP_WRITE
    |=> o_nv_req.wr && state == ARNV_BUSY
        && o_nv_req.wdata == $past(i_wdata[ARNV_DATA_LSB +: ARNV_DATA_W]))
    else $error("nv write did not start");

  a_read_start: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    start && wr_op == ARNV_OP_READ
    |=> o_nv_req.rd && !o_nv_req.wr && state == ARNV_BUSY)
    else $error("nv read did not start");

  a_busy_req_match: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state == ARNV_BUSY) == (o_nv_req.wr || o_nv_req.rd))
    else $error("busy flag and memory request disagree");

  a_single_access: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !(o_nv_req.wr && o_nv_req.rd))
    else $error("write and read requested together");

  a_disabled_keep: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    reg_wr && state == ARNV_IDLE && !i_wdata[ARNV_EN_BIT]
    |=> $stable(o_nv_req))
    else $error("memory request changed with enable low");

  a_write_keep: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == ARNV_BUSY && o_nv_req.wr && i_nv_ack
    |=> $stable(data))
    else $error("data byte changed by write ack");

  a_read_data: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == ARNV_BUSY && o_nv_req.rd && i_nv_ack
    |=> data == $past(i_nv_rdata))
    else $error("read byte not captured");

  // read-back
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= ARNV_RESET_VALUE;
    end else if (i_sel && i_rd && i_addr == ARNV_REG_OFFSET) begin
      o_rdata <= {state == ARNV_BUSY, op, 5'h00, data, 16'h0000};
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  a_rdata_ready: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_sel && i_rd && i_addr == ARNV_REG_OFFSET
    |=> o_rdata[ARNV_EN_BIT] == $past(state == ARNV_BUSY))
    else $error("ready bit read back wrong");

  a_rdata_fields: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_sel && i_rd && i_addr == ARNV_REG_OFFSET
    |=> o_rdata[ARNV_OP_HI_BIT:ARNV_OP_LO_BIT] == $past(op)
        && o_rdata[ARNV_DATA_LSB +: ARNV_DATA_W] == $past(data))
    else $error("operation or data byte read back wrong");

  a_rdata_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !(i_sel && i_rd && i_addr == ARNV_REG_OFFSET)
    |=> o_rdata == 32'h00000000)
    else $error("read data shown without a read");
endmodule

// ===== arnv_pkg.sv
// Purpose: constants and types for the add-on reset and nv memory control register
// Assumes: 32-bit add-on register bus with byte addresses
// Notes:   one register at 3Ch
package arnv_pkg;
  localparam logic [7:0]  ARNV_REG_OFFSET   = 8'h3C;
  localparam logic [31:0] ARNV_RESET_VALUE  = 32'h00000000;
  localparam int          ARNV_EN_BIT       = 31;
  localparam int          ARNV_OP_HI_BIT    = 30;
  localparam int          ARNV_OP_LO_BIT    = 29;
  localparam int          ARNV_MBOX_CLR_BIT = 28;
  localparam int          ARNV_FIFO_RST_BIT = 27;
  localparam int          ARNV_DATA_LSB     = 16;
  localparam int          ARNV_DATA_W       = 8;
  localparam int          ARNV_ADDR_W       = 16;

  typedef enum logic [1:0] {
    ARNV_OP_ADDR_LO,
    ARNV_OP_ADDR_HI,
    ARNV_OP_WRITE,
    ARNV_OP_READ
  } arnv_op_t;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [ARNV_ADDR_W-1:0] addr;
    logic [ARNV_DATA_W-1:0] wdata;
  } arnv_nv_req_t;
endpackage

// ===== arnv_nv_model.sv
// Purpose: external nv memory model behind the request/ack port
// Assumes: one access at a time
// Notes:   read byte toggles every cycle outside an answer
`timescale 1ns/1ps
module arnv_nv_model
  import arnv_pkg::*;
#(parameter int DELAY = 6)
(
  input  wire logic         i_ref_clk,
  input  wire arnv_nv_req_t i_req,
  output logic              o_ack,
  output logic [7:0]        o_rdata
);
  logic [7:0] mem [0:65535];
  int         cnt = 0;
  initial o_ack = 1'b0;
  initial o_rdata = 8'h00;
  always @(posedge i_ref_clk) begin
    o_rdata <= ~o_rdata;
    o_ack   <= 1'b0;
    if ((i_req.wr || i_req.rd) && !o_ack) begin
      cnt <= cnt + 1;
      if (cnt == DELAY) begin
        o_ack <= 1'b1;
        cnt   <= 0;
        if (i_req.wr) mem[i_req.addr] <= i_req.wdata;
        if (i_req.rd) o_rdata <= mem[i_req.addr];
      end
    end
  end
endmodule

// ===== arnv_ctrl_tb_top.sv
// Purpose: self-checking bench for the reset and nv memory control register
// Assumes: bus inputs change on the falling edge
// Notes:   nv model answers after a few cycles
`timescale 1ns/1ps
module arnv_ctrl_tb_top
  import arnv_pkg::*;
;
  logic         clk, nrst, sel, wr, rd, ack, mb, fr;
  logic [7:0]   addr, nvd;
  logic [31:0]  wdata, rdata, got;
  arnv_nv_req_t req;
  int           n_errors = 0, n_tests = 0, n_cyc = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  arnv_ctrl dut (.i_ref_clk(clk), .i_nrst(nrst), .i_sel(sel), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_mbox_flags_clr(mb),
    .o_ptrd_fifo_rst(fr), .o_nv_req(req), .i_nv_ack(ack), .i_nv_rdata(nvd));
  arnv_nv_model #(.DELAY(6)) nv (.i_ref_clk(clk), .i_req(req), .o_ack(ack), .o_rdata(nvd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {sel, wr, rd, addr, wdata} = {1'b1, w, !w, a, d};
    @(negedge clk);
    {sel, wr, rd} = 3'b000;
    got = rdata;
  endtask
  task automatic wait_ready();
    bus(1'b0, 8'h3C, 32'h0);
    chk(got[31], 1'b1);
    for (int i = 0; i < 20 && got[31]; i++) bus(1'b0, 8'h3C, 32'h0);
    chk(got[31], 1'b0);
  endtask
  task automatic t_reset();
    bus(1'b0, 8'h3C, 32'h0);
    chk(got, ARNV_RESET_VALUE);
    bus(1'b0, 8'h38, 32'h0);
    chk(got, 32'h0);
  endtask
  task automatic t_pulses();
    bus(1'b1, 8'h3C, 32'h7000_0000);
    chk({mb, fr, req.wr, req.rd}, 4'h8);
    bus(1'b1, 8'h3C, 32'h0800_0000);
    chk({mb, fr}, 2'h1);
    bus(1'b1, 8'h38, 32'h1800_0000);
    chk({mb, fr}, 2'h0);
    bus(1'b0, 8'h3C, 32'h0);
    chk(got[28:27], 2'h0);
  endtask
  task automatic t_nv_access(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 8'h3C, {8'h80, a[7:0], 16'h0});
    chk(req.wr | req.rd, 1'b0);
    bus(1'b1, 8'h3C, {8'hA0, a[15:8], 16'h0});
    bus(1'b1, 8'h3C, {8'hC0, d, 16'h0});
    chk({req.wr, req.rd, req.addr, req.wdata}, {2'h2, a, d});
    bus(1'b1, 8'h3C, {8'hE0, ~d, 16'h0});
    chk({req.wr, req.rd, req.wdata}, {2'h2, d});
    wait_ready();
    chk(got[23:16], d);
    bus(1'b1, 8'h3C, 32'hE000_0000);
    chk({req.wr, req.rd, req.addr}, {2'h1, a});
    wait_ready();
    chk(got[23:16], d);
    chk(got[30:29], 2'h3);
  endtask
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {nrst, sel, wr, rd, addr, wdata} = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_pulses();
    t_nv_access(16'hA55A, 8'h3C);
    t_nv_access(16'h00FF, 8'hC3);
    tally_and_finish();
  end
endmodule
